/* File: apsi_defs.svh */
// timing and reset constants for the activity power state indicators
`ifndef APSI_DEFS_SVH
`define APSI_DEFS_SVH
`define APSI_CLK_HZ 20000000
`define APSI_CODEC_RST_NS 1000
`define APSI_CODEC_RST_CYC ((`APSI_CODEC_RST_NS * (`APSI_CLK_HZ / 1000000) + 999) / 1000)
`define APSI_QUIET_CYC 16
`define APSI_RST_IND 1'b1
`endif

/* File: apsi_pkg.sv */
// types for the activity power state indicators
package apsi_pkg;
  typedef enum logic [1:0] {
    APSI_ACTIVE,
    APSI_IDLE,
    APSI_STANDBY
  } apsi_state_e;
endpackage

/* File: apsi_sync3.sv */
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module apsi_sync3 (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // async in, filtered out
  input wire logic i_async,
  output logic o_level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  wire agree = (s2_q == s3_q);
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      // start at the idle-high line level so release shows no false edge
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      lvl_q <= 1'b1;
    end else if (i_ce) begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (agree) begin
        lvl_q <= s3_q;
      end
    end
  end
  assign o_level = lvl_q;
endmodule

/* File: apsi_top.sv */
// power and activity state indicators with codec reset
`timescale 1ns/1ps
`include "apsi_defs.svh"
module apsi_top #(
  parameter int QUIET_CYC = `APSI_QUIET_CYC,
  parameter int CODEC_RST_CYC = `APSI_CODEC_RST_CYC
) (
  // clock, enable, reset
  input wire logic i_core_clk,
  input wire logic i_ce,
  input wire logic i_rst,
  // activity sources
  input wire logic i_packet_wake_input,
  input wire logic i_encoder_busy,
  input wire logic i_decoder_busy,
  input wire logic i_packet_pending,
  // configuration and codec reset request
  input wire logic i_low_power_en,
  input wire logic i_codec_reset_req,
  // indicators
  output logic o_standby_indicator_n,
  output logic o_idle_indicator_n,
  output logic o_codec_engine_active_n,
  output logic o_audio_codec_reset_n,
  output apsi_pkg::apsi_state_e o_state
);
  import apsi_pkg::*;

  // counters are 16 bits wide and must count at least once
  if (QUIET_CYC < 1 || QUIET_CYC > 65535) begin : g_bad_quiet
    $error("apsi_top: QUIET_CYC out of range");
  end
  if (CODEC_RST_CYC < 1 || CODEC_RST_CYC > 65535) begin : g_bad_crst
    $error("apsi_top: CODEC_RST_CYC out of range");
  end

  logic wake_lvl;
  logic wake_prev_q;
  apsi_state_e state_q;
  apsi_state_e state_d;
  logic [15:0] quiet_q;
  logic [15:0] crst_q;
  logic stb_n_q;
  logic idle_n_q;
  logic run_n_q;
  logic crst_n_q;

  // wake pin comes from outside; idle line level is high (uart) or sync inverted
  apsi_sync3 u_wake_sync (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_async(i_packet_wake_input),
    .o_level(wake_lvl)
  );

  // wake edge in either direction (falling on uart start bit) or low level counts as activity
  wire wake_edge = (wake_prev_q != wake_lvl);
  wire wake_low = ~wake_lvl;
  wire wake_evt = wake_edge | wake_low;
  wire engine_busy = i_encoder_busy | i_decoder_busy;
  wire activity = engine_busy | i_packet_pending | wake_evt;
  wire quiet_done = (quiet_q == 16'(QUIET_CYC));
  wire crst_busy = (crst_q != 16'h0000);
  // registered indicator and codec reset next values
  wire stb_n_d = (state_d != APSI_STANDBY);
  wire idle_n_d = (state_d != APSI_IDLE);
  wire run_n_d = ~engine_busy;
  wire crst_n_d = ~(i_codec_reset_req | (crst_q > 16'h0001));

  always_comb begin
    state_d = state_q;
    case (state_q)
      APSI_ACTIVE: begin
        if (!activity && quiet_done) begin
          state_d = i_low_power_en ? APSI_STANDBY : APSI_IDLE;
        end
      end
      APSI_IDLE, APSI_STANDBY: begin
        if (activity) begin
          state_d = APSI_ACTIVE;
        end
      end
      default: state_d = APSI_ACTIVE;
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= APSI_ACTIVE;
      quiet_q <= 16'h0000;
      wake_prev_q <= 1'b1;
    end else if (i_ce) begin
      state_q <= state_d;
      wake_prev_q <= wake_lvl;
      if (activity) begin
        quiet_q <= 16'h0000;
      end else if (!quiet_done) begin
        quiet_q <= quiet_q + 16'h0001;
      end
    end
  end

  // standby and idle indicators track the next state so they change with it; run follows engine busy
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      stb_n_q <= `APSI_RST_IND;
      idle_n_q <= `APSI_RST_IND;
      run_n_q <= `APSI_RST_IND;
    end else if (i_ce) begin
      stb_n_q <= stb_n_d;
      idle_n_q <= idle_n_d;
      run_n_q <= run_n_d;
    end
  end

  // codec reset: held low through reset, then for a minimum pulse per request
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      crst_q <= 16'h0000;
      crst_n_q <= 1'b0;
    end else if (i_ce) begin
      if (i_codec_reset_req) begin
        crst_q <= 16'(CODEC_RST_CYC);
      end else if (crst_busy) begin
        crst_q <= crst_q - 16'h0001;
      end
      crst_n_q <= crst_n_d;
    end
  end

  assign o_standby_indicator_n = stb_n_q;
  assign o_idle_indicator_n = idle_n_q;
  assign o_codec_engine_active_n = run_n_q;
  assign o_audio_codec_reset_n = crst_n_q;
  assign o_state = state_q;

  standby_match_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_standby_indicator_n == (state_q != APSI_STANDBY))
    else $error("standby indicator mismatch");
  standby_entry_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $fell(o_standby_indicator_n) |-> $past(i_low_power_en) && !$past(engine_busy)
    && !$past(i_packet_pending))
    else $error("standby entered wrongly");
  idle_match_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_idle_indicator_n == (state_q != APSI_IDLE))
    else $error("idle indicator mismatch");
  idle_entry_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_ce && state_q == APSI_ACTIVE && !activity && quiet_done && !i_low_power_en)
    |=> state_q == APSI_IDLE)
    else $error("idle not entered");
  run_ind_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_ce && engine_busy) |=> !o_codec_engine_active_n)
    else $error("run indicator not low");
  codec_rst_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_ce && i_codec_reset_req) |=> !o_audio_codec_reset_n)
    else $error("codec reset not driven");
  wake_exit_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_ce && state_q != APSI_ACTIVE && activity) |=> state_q == APSI_ACTIVE
    && o_idle_indicator_n && o_standby_indicator_n)
    else $error("no wake on activity");
  quiet_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state_q == APSI_ACTIVE && !quiet_done) |=> state_q == APSI_ACTIVE)
    else $error("left active too early");

  // steps of entering and leaving the low-power states
  sequence quiet_reached_s;
    i_ce && state_q == APSI_ACTIVE && !activity && quiet_done;
  endsequence
  sequence standby_shown_s;
    state_q == APSI_STANDBY && !o_standby_indicator_n && o_idle_indicator_n;
  endsequence
  sequence wake_seen_s;
    i_ce && state_q != APSI_ACTIVE && !wake_lvl;
  endsequence
  sequence back_active_s;
    state_q == APSI_ACTIVE && o_idle_indicator_n && o_standby_indicator_n;
  endsequence

  // step checks and output-level checks
  standby_reach_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    quiet_reached_s ##0 i_low_power_en |=> standby_shown_s)
    else $error("standby not entered");
  wake_level_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    wake_seen_s |=> back_active_s)
    else $error("wake line ignored");
  pending_wake_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_ce && state_q != APSI_ACTIVE && i_packet_pending) |=> back_active_s)
    else $error("pending work ignored");
  idle_only_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $fell(o_idle_indicator_n) |-> !$past(i_low_power_en))
    else $error("idle entered with low power");
  ind_exclusive_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_standby_indicator_n || o_idle_indicator_n)
    else $error("standby and idle both shown");
  run_release_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_ce && !engine_busy) |=> o_codec_engine_active_n)
    else $error("run indicator stuck low");
  codec_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_ce && crst_q > 16'h0001) |=> !o_audio_codec_reset_n)
    else $error("codec reset released early");
  reset_hold_a: assert property (@(posedge i_core_clk)
    i_rst ##1 i_rst |-> !o_audio_codec_reset_n
    && o_standby_indicator_n && o_idle_indicator_n)
    else $error("outputs wrong in reset");
  freeze_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !i_ce |=> $stable(state_q) && $stable(o_standby_indicator_n)
    && $stable(o_idle_indicator_n))
    else $error("state moved while frozen");
  quiet_bound_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    quiet_q <= 16'(QUIET_CYC))
    else $error("quiet counter overran");
endmodule

/* File: apsi_wake_src.sv */
// packet receive line model feeding the wake input
`timescale 1ns/1ps
module apsi_wake_src (
  // clock, reset and send requests
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_send,
  input wire logic i_send_fsync,
  // wake pin
  output logic o_wake
);
  logic [3:0] cnt_q;
  // line idles high; a uart start bit holds it low for eight cycles
  // an inverted frame sync holds it low for two cycles
  assign o_wake = (cnt_q == 4'h0);
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= 4'h0;
    end else if (i_send) begin
      cnt_q <= 4'h8;
    end else if (i_send_fsync) begin
      cnt_q <= 4'h2;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule

/* File: activity_power_state_indicators_bench.sv */
// self-checking bench for the power state indicators
`timescale 1ns/1ps
module activity_power_state_indicators_bench;
  import apsi_pkg::*;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, send = 1'b0, enc = 1'b0, dec = 1'b0;
  logic pend = 1'b0, lp = 1'b0, creq = 1'b0, fs = 1'b0, wake, sb_n, id_n, run_n, crst_n;
  apsi_state_e st;
  int num_errors = 0, n_tests = 0, cyc = 0;
  initial forever #25 clk = ~clk;
  apsi_wake_src src_u (.i_core_clk(clk), .i_rst(rst), .i_send(send), .i_send_fsync(fs),
    .o_wake(wake));
  apsi_top #(.QUIET_CYC(4), .CODEC_RST_CYC(3)) dut_u (.i_core_clk(clk), .i_ce(ce),
    .i_rst(rst), .i_packet_wake_input(wake), .i_encoder_busy(enc), .i_decoder_busy(dec),
    .i_packet_pending(pend), .i_low_power_en(lp), .i_codec_reset_req(creq),
    .o_standby_indicator_n(sb_n), .o_idle_indicator_n(id_n),
    .o_codec_engine_active_n(run_n), .o_audio_codec_reset_n(crst_n), .o_state(st));
  task check(input string nm, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task results;
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task cycles(input int n);
    repeat (n) @(negedge clk);
  endtask
  task t_reset;
    check("codec reset", 1'b0, crst_n);
    check("standby", 1'b1, sb_n);
    @(posedge clk) rst <= 1'b0;
    cycles(2);
    check("codec reset", 1'b1, crst_n);
  endtask
  task t_idle;
    cycles(12);
    check("idle", 1'b0, id_n);
    check("standby", 1'b1, sb_n);
    check("state idle", 1'b1, st === APSI_IDLE);
    @(posedge clk) send <= 1'b1;
    @(posedge clk) send <= 1'b0;
    cycles(6);
    check("idle", 1'b1, id_n);
  endtask
  task t_standby;
    @(posedge clk) lp <= 1'b1;
    cycles(20);
    check("standby", 1'b0, sb_n);
    check("idle", 1'b1, id_n);
    @(posedge clk) pend <= 1'b1;
    cycles(2);
    check("standby", 1'b1, sb_n);
    @(posedge clk) pend <= 1'b0;
  endtask
  task t_run;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) begin
        enc <= (i == 0);
        dec <= (i == 1);
      end
      cycles(2);
      check("run", 1'b0, run_n);
      @(posedge clk) begin
        enc <= 1'b0;
        dec <= 1'b0;
      end
      cycles(2);
      check("run", 1'b1, run_n);
    end
  endtask
  task t_codec;
    @(posedge clk) creq <= 1'b1;
    @(posedge clk) creq <= 1'b0;
    cycles(1);
    check("codec reset", 1'b0, crst_n);
    cycles(4);
    check("codec reset", 1'b1, crst_n);
  endtask
  task t_fsync;
    cycles(2);
    check("standby", 1'b0, sb_n);
    @(posedge clk) fs <= 1'b1;
    @(posedge clk) fs <= 1'b0;
    cycles(8);
    check("standby", 1'b1, sb_n);
    check("state active", 1'b1, st === APSI_ACTIVE);
  endtask
  task t_freeze;
    cycles(6);
    @(posedge clk) ce <= 1'b0;
    @(posedge clk) pend <= 1'b1;
    cycles(4);
    check("standby frozen", 1'b0, sb_n);
    check("codec reset frozen", 1'b1, crst_n);
    @(posedge clk) ce <= 1'b1;
    cycles(2);
    check("standby", 1'b1, sb_n);
    @(posedge clk) pend <= 1'b0;
  endtask
  task t_midreset;
    cycles(8);
    check("standby", 1'b0, sb_n);
    @(posedge clk) rst <= 1'b1;
    cycles(2);
    check("codec reset", 1'b0, crst_n);
    check("standby", 1'b1, sb_n);
    check("idle", 1'b1, id_n);
    @(posedge clk) rst <= 1'b0;
    cycles(2);
    check("codec reset", 1'b1, crst_n);
    check("state active", 1'b1, st === APSI_ACTIVE);
    cycles(6);
    check("standby", 1'b0, sb_n);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      results;
    end
  end
  initial begin
    cycles(8);
    t_reset;
    t_idle;
    t_standby;
    t_run;
    t_codec;
    t_fsync;
    t_freeze;
    t_midreset;
    results;
  end
endmodule
